/* File: sol_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------
// shared constants for the secured otp lock control
// ----------------------------------------------------------------
package sol_pkg;
   // command opcodes decoded by this block
   localparam logic [7:0] OP_OTP_ENTER = 8'hB1; // otp_mode_enter_cmd
   localparam logic [7:0] OP_OTP_EXIT = 8'hC1;  // otp_mode_exit_cmd
   localparam logic [7:0] OP_SEC_WRITE = 8'h2F; // security register write
   localparam logic [7:0] OP_SEC_READ = 8'h2B;  // security register read
   // security register field positions
   localparam int SEC_FACT_BIT = 0;             // factory lock indicator
   localparam int SEC_CUST_BIT = 1;             // otp_customer_lock_bit
   localparam logic [7:0] SEC_RESET = 8'h00;    // value before straps load
   // otp address map
   localparam int OTP_ADDR_W = 9;               // 512 bytes = 4K bits
   localparam logic [23:0] SERIAL_LAST = 24'h00000F; // serial_number_field end
   localparam logic [23:0] OTP_LAST = 24'h0001FF;    // user area end
   // security write frame must hold exactly this many data bytes
   localparam logic [1:0] SEC_DATA_BYTES = 2'h1;
   // power-up write ignore window
   localparam int CLK_HZ = 10_000_000;          // mclk rate
   localparam int PWRUP_MS = 10;                // longest ignore time, ms
   localparam int PWRUP_CYC = PWRUP_MS * (CLK_HZ / 1000); // rounds down
   localparam int PU_CNT_W = 17;                // holds PWRUP_CYC
   localparam logic [PU_CNT_W-1:0] PU_CNT_RESET = 17'h00000;

   // complete state of the control block
   typedef struct packed {
      logic strapDone;                 // nonvolatile bits captured
      logic factLock;                  // factory lock copy
      logic custLock;                  // customer lock copy
      logic otpMode;                   // otp window selected
      logic secPend;                   // security write frame open
      logic [1:0] dataCnt;             // data bytes seen, saturating
      logic [7:0] dataByte;            // first data byte of the frame
      logic [PU_CNT_W-1:0] puCnt;      // power-up window counter
      logic puReady;                   // writes now honoured
      logic mainWrEn;                  // main array write granted
      logic otpWrEn;                   // otp write granted
      logic serialSel;                 // grant hits serial field
      logic [OTP_ADDR_W-1:0] otpAddr;  // otp byte address of grant
      logic lockProg;                  // program customer lock cell
      logic refused;                   // command refused
      logic [7:0] secReg;              // security register image
   } sol_state_t;
endpackage : sol_pkg
`default_nettype wire

/* File: sol_gate_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// write gating signals between control and gate
// ----------------------------------------------------------------
interface sol_gate_if;
   logic otpMode;            // otp window selected
   logic locked;             // factory or customer lock
   logic puReady;            // power-up window over
   logic erase;              // request is an erase
   logic [23:0] addr;        // request address
   logic mainWrOk;           // main array write allowed
   logic otpWrOk;            // otp write allowed
   logic serialSel;          // address in serial field
   modport ctrl (output otpMode, output locked, output puReady, output erase,
                 output addr, input mainWrOk, input otpWrOk, input serialSel);
   modport gate (input otpMode, input locked, input puReady, input erase,
                 input addr, output mainWrOk, output otpWrOk, output serialSel);
endinterface : sol_gate_if
`default_nettype wire

/* File: sol_gate.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// address map and write permission for program/erase requests
// ----------------------------------------------------------------
module sol_gate (
   // link to control
   sol_gate_if.gate g
);
   logic inOtp;   // address inside the otp area
   logic inSer;   // address inside the serial field

   // decode, purely combinational so the grant lands one edge later
   always_comb begin
      inOtp = (g.addr <= sol_pkg::OTP_LAST);
      inSer = (g.addr <= sol_pkg::SERIAL_LAST);
      g.serialSel = inSer;
      // main array closed while otp window is open
      g.mainWrOk = g.puReady && !g.otpMode;
      // locked otp silently drops the write, no error raised
      g.otpWrOk = g.puReady && g.otpMode && !g.locked && !g.erase && inOtp;
   end
endmodule : sol_gate
`default_nettype wire

/* File: sol_lock_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module sol_lock_ctrl #(
   parameter int PWRUP_CYC = sol_pkg::PWRUP_CYC  // power-up ignore length
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // nonvolatile lock cells
   input wire logic factoryLockIn,
   input wire logic custLockIn,
   // decoded commands from the command engine
   input wire logic cmdValid,
   input wire logic [7:0] cmdOpcode,
   input wire logic cmdIsStatusWr,
   input wire logic cmdIsRead,
   input wire logic dataValid,
   input wire logic [7:0] dataIn,
   input wire logic frameEnd,
   input wire logic frameAligned,
   // program/erase requests
   input wire logic wrReq,
   input wire logic wrErase,
   input wire logic [23:0] wrAddr,
   // grants to array engines
   output logic mainWrEn,
   output logic otpWrEn,
   output logic otpSerialSel,
   output logic [sol_pkg::OTP_ADDR_W-1:0] otpAddr,
   // status
   output logic otpMode,
   output logic [7:0] secReg,
   output logic lockProg,
   output logic cmdRefused,
   output logic writeReady
);
   // ----------------------------------------------------------------
   // state and gate
   // ----------------------------------------------------------------
   sol_pkg::sol_state_t st_r;   // registered state
   sol_pkg::sol_state_t st_nxt; // next state
   sol_gate_if gIf ();          // link to the gate
   logic lockedNow;             // either lock in force

   assign lockedNow = st_r.factLock || st_r.custLock;
   assign gIf.otpMode = st_r.otpMode;
   assign gIf.locked = lockedNow;
   assign gIf.puReady = st_r.puReady;
   assign gIf.erase = wrErase;
   assign gIf.addr = wrAddr;

   sol_gate uGate (
      .g (gIf.gate)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // pulses default low
      st_nxt.mainWrEn = 1'b0;
      st_nxt.otpWrEn = 1'b0;
      st_nxt.lockProg = 1'b0;
      st_nxt.refused = 1'b0;
      // lock cells caught once after release, never under reset
      if (!st_r.strapDone) begin
         st_nxt.strapDone = 1'b1;
         st_nxt.factLock = factoryLockIn;
         st_nxt.custLock = custLockIn;
      end
      // writes ignored until the power-up window closes
      if (!st_r.puReady) begin
         st_nxt.puCnt = st_r.puCnt + 1'b1;
         if (st_r.puCnt == sol_pkg::PU_CNT_W'(PWRUP_CYC - 1)) begin
            st_nxt.puReady = 1'b1;
         end
      end
      // a new opcode opens a new frame
      if (cmdValid) begin
         st_nxt.secPend = 1'b0;
         st_nxt.dataCnt = 2'h0;
         unique case (cmdOpcode)
            sol_pkg::OP_OTP_ENTER: begin
               st_nxt.otpMode = 1'b1;
            end
            sol_pkg::OP_OTP_EXIT: begin
               st_nxt.otpMode = 1'b0;
            end
            sol_pkg::OP_SEC_WRITE: begin
               // no write-enable latch consulted here
               if (st_r.otpMode) begin
                  st_nxt.refused = 1'b1;
               end else begin
                  st_nxt.secPend = 1'b1;
               end
            end
            default: begin
               // reads, including the security read, always pass
               if (st_r.otpMode && cmdIsStatusWr) begin
                  st_nxt.refused = 1'b1;
               end else if (st_r.otpMode && lockedNow && !cmdIsRead) begin
                  st_nxt.refused = 1'b1;
               end
            end
         endcase
      end
      // collect data bytes of the security write
      if (dataValid && st_r.secPend && st_r.dataCnt != 2'h3) begin
         st_nxt.dataCnt = st_r.dataCnt + 2'h1;
         if (st_r.dataCnt == 2'h0) begin
            st_nxt.dataByte = dataIn;
         end
      end
      // commit only on a clean byte boundary with one data byte
      if (frameEnd && st_r.secPend) begin
         st_nxt.secPend = 1'b0;
         if (frameAligned && st_r.dataCnt == sol_pkg::SEC_DATA_BYTES
             && st_r.puReady && !lockedNow) begin
            if (st_r.dataByte[sol_pkg::SEC_CUST_BIT]) begin
               st_nxt.custLock = 1'b1;
               st_nxt.lockProg = 1'b1;
            end
         end else begin
            st_nxt.refused = 1'b1;
         end
      end
      // program/erase grant, one edge after the request
      if (wrReq) begin
         st_nxt.mainWrEn = gIf.mainWrOk;
         st_nxt.otpWrEn = gIf.otpWrOk;
         st_nxt.serialSel = gIf.serialSel;
         st_nxt.otpAddr = wrAddr[sol_pkg::OTP_ADDR_W-1:0];
      end
      // register image tracks the lock copies every cycle
      st_nxt.secReg = 8'h00;
      st_nxt.secReg[sol_pkg::SEC_FACT_BIT] = st_nxt.factLock;
      st_nxt.secReg[sol_pkg::SEC_CUST_BIT] = st_nxt.custLock;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.secReg <= sol_pkg::SEC_RESET;
         st_r.puCnt <= sol_pkg::PU_CNT_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs come straight from state fields
   assign mainWrEn = st_r.mainWrEn;
   assign otpWrEn = st_r.otpWrEn;
   assign otpSerialSel = st_r.serialSel;
   assign otpAddr = st_r.otpAddr;
   assign otpMode = st_r.otpMode;
   assign secReg = st_r.secReg;
   assign lockProg = st_r.lockProg;
   assign cmdRefused = st_r.refused;
   assign writeReady = st_r.puReady;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_mode_enter: assert property (@(posedge mclk) disable iff (!arst_n)
      cmdValid && cmdOpcode == sol_pkg::OP_OTP_ENTER |=> otpMode)
      else $error("otp mode not entered");
   chk_mode_exit: assert property (@(posedge mclk) disable iff (!arst_n)
      cmdValid && cmdOpcode == sol_pkg::OP_OTP_EXIT |=> !otpMode)
      else $error("otp mode not left");
   chk_main_block: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && otpMode |=> !mainWrEn)
      else $error("main write granted in otp mode");
   chk_locked_otp: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && (secReg[0] || secReg[1]) |=> !otpWrEn)
      else $error("locked otp written");
   chk_lock_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
      st_r.strapDone && secReg[1] |=> secReg[1] [*2])
      else $error("customer lock cleared");
   chk_misaligned_end: assert property (@(posedge mclk) disable iff (!arst_n)
      frameEnd && st_r.secPend && !frameAligned |=> cmdRefused && $stable(secReg))
      else $error("misaligned security write applied");
   chk_secwr_sets: assert property (@(posedge mclk) disable iff (!arst_n)
      frameEnd && frameAligned && st_r.secPend && st_r.dataCnt == 2'h1 && st_r.puReady
      && st_r.dataByte[1] && !st_r.factLock && !st_r.custLock |=> secReg[1] && lockProg)
      else $error("customer lock not set");
   chk_serial_map: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && otpMode && writeReady && !wrErase && !secReg[0] && !secReg[1]
      && wrAddr <= sol_pkg::SERIAL_LAST |=> otpWrEn && otpSerialSel)
      else $error("serial field write not granted");
   chk_factory_bit: assert property (@(posedge mclk) disable iff (!arst_n)
      st_r.strapDone |-> secReg[0] == st_r.factLock)
      else $error("factory bit mismatch");
   chk_pwrup_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && !writeReady |=> !mainWrEn && !otpWrEn)
      else $error("write granted during power-up window");
   chk_otp_secwr: assert property (@(posedge mclk) disable iff (!arst_n)
      cmdValid && cmdOpcode == sol_pkg::OP_SEC_WRITE && otpMode |=> cmdRefused)
      else $error("security write accepted in otp mode");
endmodule : sol_lock_ctrl
`default_nettype wire

/* File: sol_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// host side command engine model, one strobe per call
// ----------------------------------------------------------------
module sol_host_model (
   // clock
   input wire logic mclk,
   // decoded command stream
   output logic cmdValid,
   output logic [7:0] cmdOpcode,
   output logic cmdIsStatusWr,
   output logic cmdIsRead,
   output logic dataValid,
   output logic [7:0] dataIn,
   output logic frameEnd,
   output logic frameAligned,
   // program/erase requests
   output logic wrReq,
   output logic wrErase,
   output logic [23:0] wrAddr
);
   // idle; buses hold a pattern, never a stale value
   initial begin
      {cmdValid, cmdIsStatusWr, cmdIsRead, dataValid} = 4'h0;
      {frameEnd, frameAligned, wrReq, wrErase} = 4'h0;
      cmdOpcode = 8'hA5;
      dataIn = 8'h5A;
      wrAddr = 24'hA5A5A5;
   end
   // opcode strobe; released qualifiers are inverted
   task automatic op(input logic [7:0] c, input logic sw, input logic rd);
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdOpcode <= c;
      cmdIsStatusWr <= sw;
      cmdIsRead <= rd;
      @(posedge mclk);
      cmdValid <= 1'b0;
      cmdOpcode <= ~c;
      cmdIsStatusWr <= ~sw;
      cmdIsRead <= ~rd;
   endtask : op
   // one whole data byte
   task automatic data(input logic [7:0] b);
      @(posedge mclk);
      dataValid <= 1'b1;
      dataIn <= b;
      @(posedge mclk);
      dataValid <= 1'b0;
      dataIn <= ~b;
   endtask : data
   // chip select rise, on or off a byte boundary
   task automatic fend(input logic al);
      @(posedge mclk);
      frameEnd <= 1'b1;
      frameAligned <= al;
      @(posedge mclk);
      frameEnd <= 1'b0;
      frameAligned <= ~al;
   endtask : fend
   // program or erase request
   task automatic wreq(input logic er, input logic [23:0] a);
      @(posedge mclk);
      wrReq <= 1'b1;
      wrErase <= er;
      wrAddr <= a;
      @(posedge mclk);
      wrReq <= 1'b0;
      wrErase <= ~er;
      wrAddr <= ~a;
   endtask : wreq
endmodule : sol_host_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic mclk, arst_n, factoryLockIn, custLockIn;
   logic cmdValid, cmdIsStatusWr, cmdIsRead, dataValid, frameEnd, frameAligned;
   logic wrReq, wrErase, mainWrEn, otpWrEn, otpSerialSel, otpMode;
   logic lockProg, cmdRefused, writeReady;
   logic [7:0] cmdOpcode, dataIn, secReg;
   logic [23:0] wrAddr, seen, r;
   logic [8:0] otpAddr, addrE;
   logic mode, rdy, selE, fact, cust; // expected device state
   int n = 0; // negedges so far
   int fails = 0;
   int checked = 0;
   int atQ[$]; // due negedge of each note
   logic [23:0] expQ[$];
   logic [23:0] tbl[4] = '{24'h000000, 24'h00000F, 24'h000010, 24'h0001FF};
   assign seen = {mainWrEn, otpWrEn, lockProg, cmdRefused, otpMode, writeReady,
                  otpSerialSel, otpAddr, secReg};
   sol_host_model host (.mclk, .cmdValid, .cmdOpcode, .cmdIsStatusWr, .cmdIsRead,
      .dataValid, .dataIn, .frameEnd, .frameAligned, .wrReq, .wrErase, .wrAddr);
   sol_lock_ctrl #(.PWRUP_CYC(16)) uut (.mclk, .arst_n, .factoryLockIn, .custLockIn,
      .cmdValid, .cmdOpcode, .cmdIsStatusWr, .cmdIsRead, .dataValid, .dataIn,
      .frameEnd, .frameAligned, .wrReq, .wrErase, .wrAddr, .mainWrEn, .otpWrEn,
      .otpSerialSel, .otpAddr, .otpMode, .secReg, .lockProg, .cmdRefused, .writeReady);
   initial begin
      mclk = 1'b0;
      arst_n = 1'b0;
      factoryLockIn = 1'b0;
      custLockIn = 1'b0;
   end
   always #50 mclk = ~mclk;
   // ----------------------------------------------------------------
   // watcher: a due note is compared; pulses without a note are faults
   // ----------------------------------------------------------------
   always @(negedge mclk) begin
      n = n + 1;
      if (atQ.size() > 0 && atQ[0] == n) begin
         checked++;
         if (seen !== expQ[0]) begin
            $display("[FAIL] outputs expected %h seen %h", expQ[0], seen);
            fails++;
         end
         void'(atQ.pop_front());
         void'(expQ.pop_front());
      end else if ({mainWrEn, otpWrEn, lockProg, cmdRefused} !== 4'h0) begin
         $display("[FAIL] pulses expected 0 seen %h", seen);
         fails++;
      end
   end
   // ----------------------------------------------------------------
   // driver side tasks; p = {main grant, otp grant, lock prog, refused}
   // ----------------------------------------------------------------
   task automatic note(input logic [3:0] p);
      atQ.push_back(n + 1); // answer registered at return edge, stands one cycle
      expQ.push_back({p, mode, rdy, selE, addrE, 6'h00, cust, fact});
   endtask : note
   task automatic restart(input logic f, input logic c);
      @(posedge mclk);
      arst_n <= 1'b0;
      factoryLockIn <= f;
      custLockIn <= c;
      {mode, rdy, selE, addrE, fact, cust} = {3'h0, 9'h000, f, c};
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
   endtask : restart
   task automatic wr(input logic er, input logic [23:0] a, input logic [3:0] p);
      host.wreq(er, a);
      addrE = a[8:0];
      selE = (a <= 24'h00000F);
      note(p);
   endtask : wr
   task automatic cm(input logic [7:0] c, input logic sw, input logic rd,
                     input logic [3:0] p);
      host.op(c, sw, rd);
      // a refused opcode leaves the mode alone
      if (!p[0] && c == 8'hB1) mode = 1'b1;
      if (!p[0] && c == 8'hC1) mode = 1'b0;
      note(p);
   endtask : cm
   task automatic secw(input logic [7:0] b, input int nb, input logic al,
                       input logic [3:0] p);
      host.op(8'h2F, 1'b0, 1'b0);
      repeat (nb) host.data(b);
      host.fend(al);
      if (p == 4'h2) cust = 1'b1;
      note(p);
   endtask : secw
   task automatic give_verdict();
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32601));
      restart(1'b0, 1'b0);
      wr(1'b0, 24'h000010, 4'h0);
      repeat (20) @(posedge mclk);
      rdy = 1'b1;
      r = 24'($urandom);
      wr(1'b1, r, 4'h8);
      cm(8'hB1, 1'b0, 1'b0, 4'h0);
      wr(1'b1, r, 4'h0);
      foreach (tbl[i]) wr(1'b0, tbl[i], 4'h4);
      wr(1'b0, 24'($urandom % 512), 4'h4);
      cm(8'h2F, 1'b0, 1'b0, 4'h1);
      cm(8'h01, 1'b1, 1'b0, 4'h1);
      cm(8'h2B, 1'b0, 1'b1, 4'h0);
      cm(8'hC1, 1'b0, 1'b0, 4'h0);
      wr(1'b0, 24'($urandom), 4'h8);
      secw(8'h02, 1, 1'b0, 4'h1);
      secw(8'h02, 2, 1'b1, 4'h1);
      secw(8'h00, 1, 1'b1, 4'h0);
      secw(8'h02, 1, 1'b1, 4'h2);
      secw(8'h02, 1, 1'b1, 4'h1);
      cm(8'hB1, 1'b0, 1'b0, 4'h0);
      wr(1'b0, 24'h000020, 4'h0);
      cm(8'h06, 1'b0, 1'b0, 4'h1);
      cm(8'h03, 1'b0, 1'b1, 4'h0);
      restart(1'b1, 1'b0);
      repeat (20) @(posedge mclk);
      rdy = 1'b1;
      secw(8'h02, 1, 1'b1, 4'h1);
      cm(8'hB1, 1'b0, 1'b0, 4'h0);
      wr(1'b0, 24'h000005, 4'h0);
      repeat (4) @(posedge mclk);
      if (atQ.size() != 0) begin
         $display("[FAIL] pending notes expected 0 seen %0d", atQ.size());
         fails++;
      end
      give_verdict();
   end
   // watchdog, far beyond the 130 or so cycles needed
   initial begin
      #400000;
      $display("[FAIL] watchdog expected finish seen timeout");
      fails++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
